// ===== include/pamux_pkg.sv
// port a / port b alternate function mux: shared constants and types
// assumes one clock domain, synchronous active-low reset in the user
package pamux_pkg;

  // ----------------------------------------------------------------
  // pin layout
  // ----------------------------------------------------------------
  localparam int PAMUX_PA_SEG_LO = 4;   // port a bits 7..4 carry segment lines 3..0
  localparam int PAMUX_PA_COM_QLO = 1;  // port a bits 3..1 need the mux qualifier
  localparam int PAMUX_PB_LO = 1;       // lowest port b bit handled here
  localparam int PAMUX_PB_TMR_LO = 4;   // port b bits 7..4 carry timer compare outputs
  localparam int PAMUX_PB_MISO = 3;     // serial data, master in / slave out
  localparam int PAMUX_PB_MOSI = 2;     // serial data, master out / slave in
  localparam int PAMUX_PB_SCK = 1;      // serial clock
  localparam int PAMUX_PCSRC_LO = 9;    // pin change source number of port b bit 1

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // override bundle that a peripheral hands to one pin
  typedef struct packed {
    logic pu_oe;   // pullup_override_en
    logic pu_ov;   // pullup_override_val
    logic dd_oe;   // dir_override_en
    logic dd_ov;   // dir_override_val
    logic pv_oe;   // value_override_en
    logic pv_ov;   // value_override_val
    logic pt_oe;   // toggle_override_en
    logic die_oe;  // input_en_override_en
    logic die_ov;  // input_en_override_val
  } pamux_ovr_t;

  // resolved pad controls of one pin
  typedef struct packed {
    logic drv_en;   // output driver enable
    logic drv_val;  // value driven when enabled
    logic pull_en;  // pull-up enable
    logic in_en;    // digital input buffer enable
  } pamux_pad_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam pamux_pad_t PAMUX_PAD_RST = 4'h0;
  localparam logic [7:0] PAMUX_BYTE_RST = 8'h00;
  localparam logic [6:0] PAMUX_PB_RST = 7'h00;
  localparam logic PAMUX_BIT_RST = 1'b0;

endpackage : pamux_pkg

// ===== rtl/pamux_port_ab.sv
// alternate function override logic for port a bits 7..0 and port b bits 7..1
// assumes all inputs synchronous to I_REF_CLK; pad level resolved outside
//
// Behaviour
// - lcd on: pa7..4 pull, dir, input forced 0
// - pa3..1 overrides gated by mux qualifier
// - pa7..4 carry segment lines 3..0
// - pa3..0 carry common lines 3..0
// - pb7 drives timer2 compare a when output
// - pb6 drives timer1 compare b when output
// - pb5 drives timer1 compare a when output
// - pb4 drives timer0 compare a when output
// - pb7..1 feed pin change sources 15..9
// - spi master forces miso to input
// - spi slave forces mosi to input
// - spi slave forces sck to input
// - forced spi inputs keep pull-up from port bit
// - miso: slave drives, master samples
// - mosi: master drives, slave samples
// - sck: master drives clock, slave receives
// - pull-up override or plain dir/port/disable decode
// - direction override or ddr bit drives driver
// - value override or port bit, toggle inverts
// - input enable override or awake state
module pamux_port_ab (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // port registers and global controls
  input wire logic [7:0] I_PA_DIR,
  input wire logic [7:0] I_PA_OUT,
  input wire logic [7:0] I_PB_DIR,
  input wire logic [7:0] I_PB_OUT,
  input wire logic I_GLOBAL_PULLUP_DISABLE,
  input wire logic I_SLEEP,
  // lcd controller
  input wire logic I_LCD_ENABLE,
  input wire logic [2:0] I_LCD_MUX_QUALIFIER,
  input wire logic [3:0] I_LCD_SEGMENT_LINE,
  input wire logic [3:0] I_LCD_COMMON_LINE,
  // timers, bits 3..0 = pb7..pb4 compare outputs and their enables
  input wire logic [3:0] I_TMR_CMP_EN,
  input wire logic [3:0] I_TMR_CMP_OUT,
  // spi
  input wire logic I_SPI_ENABLE,
  input wire logic I_SPI_MASTER,
  input wire logic I_SPI_SLAVE_OUT,
  input wire logic I_SPI_MASTER_OUT,
  input wire logic I_SPI_SCK_OUT,
  // pin change logic, bit k = pb(k+1)
  input wire logic [6:0] I_PC_MASK,
  input wire logic I_PC_GROUP_EN,
  // port b pad inputs, bit k = pb(k+1)
  input wire logic [6:0] I_PB_PAD_IN,
  // resolved pad controls
  output pamux_pkg::pamux_pad_t [7:0] O_PA_PAD,
  output pamux_pkg::pamux_pad_t [7:1] O_PB_PAD,
  // lcd analog pad path of port a
  output logic [7:0] O_PA_ANALOG_EN,
  output logic [7:0] O_PA_ANALOG_LINE,
  // inputs returned to peripherals
  output logic [6:0] O_PIN_CHANGE_SRC,
  output logic O_SPI_MASTER_IN,
  output logic O_SPI_SLAVE_IN,
  output logic O_SPI_SCK_IN
);
  import pamux_pkg::*;

  // ----------------------------------------------------------------
  // pin resolver
  // ----------------------------------------------------------------
  // one pin's pad controls from its override bundle and port bits
  function automatic pamux_pad_t pamux_resolve(input pamux_ovr_t ovr, input logic dir,
                                               input logic out, input logic pull_off,
                                               input logic sleep);
    pamux_pad_t pad;
    // pull-up: override or plain {dir, out, pull_off} == 3'b010 decode
    pad.pull_en = ovr.pu_oe ? ovr.pu_ov : (~dir & out & ~pull_off);
    // driver enable: override or ddr bit
    pad.drv_en = ovr.dd_oe ? ovr.dd_ov : dir;
    // value: override or port bit, optionally inverted
    pad.drv_val = ovr.pv_oe ? ovr.pv_ov : (out ^ ovr.pt_oe);
    // digital input buffer: override or awake state
    pad.in_en = ovr.die_oe ? ovr.die_ov : ~sleep;
    return pad;
  endfunction : pamux_resolve

  // ----------------------------------------------------------------
  // port a: lcd segment and common lines
  // ----------------------------------------------------------------
  wire logic [7:0] pa_lcd_own; // lcd owns the pin
  wire pamux_ovr_t [7:0] pa_ovr; // override bundles of port a
  wire pamux_pad_t [7:0] next_pa_pad; // resolved port a controls
  wire logic [7:0] next_pa_line; // lcd line routed per pin

  // segment lines straight across, common lines straight across
  assign next_pa_line = {I_LCD_SEGMENT_LINE, I_LCD_COMMON_LINE};

  genvar ga;
  generate
    for (ga = 0; ga < 8; ga++) begin : g_pa
      if (ga >= PAMUX_PA_SEG_LO || ga < PAMUX_PA_COM_QLO) begin : g_plain
        // segment pins and com0 follow lcd_enable alone
        assign pa_lcd_own[ga] = I_LCD_ENABLE;
      end else begin : g_qual
        // common lines 3..1 also need the duty qualifier
        assign pa_lcd_own[ga] = I_LCD_ENABLE & I_LCD_MUX_QUALIFIER[ga - PAMUX_PA_COM_QLO];
      end
      // pull, direction and input overridden to 0; value and toggle idle
      assign pa_ovr[ga] = '{pu_oe: pa_lcd_own[ga], pu_ov: 1'b0,
                            dd_oe: pa_lcd_own[ga], dd_ov: 1'b0,
                            pv_oe: 1'b0, pv_ov: 1'b0, pt_oe: 1'b0,
                            die_oe: pa_lcd_own[ga], die_ov: 1'b0};
      assign next_pa_pad[ga] = pamux_resolve(pa_ovr[ga], I_PA_DIR[ga], I_PA_OUT[ga],
                                             I_GLOBAL_PULLUP_DISABLE, I_SLEEP);
    end
  endgenerate

  // ----------------------------------------------------------------
  // port b: timers, spi, pin change
  // ----------------------------------------------------------------
  wire logic spi_mst; // spi enabled as master
  wire logic spi_slv; // spi enabled as slave
  wire logic [7:1] pb_force_in; // spi role forces the pin to input
  wire logic [7:1] pb_pv_oe; // value override enable per pin
  wire logic [7:1] pb_pv_ov; // value override value per pin
  wire pamux_ovr_t [7:1] pb_ovr; // override bundles of port b
  wire pamux_pad_t [7:1] next_pb_pad; // resolved port b controls
  wire logic [6:0] next_pc_src; // pin change sources 15..9

  assign spi_mst = I_SPI_ENABLE & I_SPI_MASTER;
  assign spi_slv = I_SPI_ENABLE & ~I_SPI_MASTER;

  // forced inputs: miso under master, mosi and sck under slave
  assign pb_force_in[7:4] = 4'h0;
  assign pb_force_in[PAMUX_PB_MISO] = spi_mst;
  assign pb_force_in[PAMUX_PB_MOSI] = spi_slv;
  assign pb_force_in[PAMUX_PB_SCK] = spi_slv;

  // timer compare outputs take the value, ddr still gates the driver
  assign pb_pv_oe[7:4] = I_TMR_CMP_EN;
  assign pb_pv_ov[7:4] = I_TMR_CMP_OUT;
  // spi drivers: slave on miso, master on mosi and sck
  assign pb_pv_oe[PAMUX_PB_MISO] = spi_slv;
  assign pb_pv_ov[PAMUX_PB_MISO] = I_SPI_SLAVE_OUT;
  assign pb_pv_oe[PAMUX_PB_MOSI] = spi_mst;
  assign pb_pv_ov[PAMUX_PB_MOSI] = I_SPI_MASTER_OUT;
  assign pb_pv_oe[PAMUX_PB_SCK] = spi_mst;
  assign pb_pv_ov[PAMUX_PB_SCK] = I_SPI_SCK_OUT;

  genvar gb;
  generate
    for (gb = PAMUX_PB_LO; gb < 8; gb++) begin : g_pb
      // forced input keeps its pull-up on the port bit unless pull-ups are globally off
      assign pb_ovr[gb] = '{pu_oe: pb_force_in[gb],
                            pu_ov: I_PB_OUT[gb] & ~I_GLOBAL_PULLUP_DISABLE,
                            dd_oe: pb_force_in[gb], dd_ov: 1'b0,
                            pv_oe: pb_pv_oe[gb], pv_ov: pb_pv_ov[gb], pt_oe: 1'b0,
                            die_oe: I_PC_MASK[gb - PAMUX_PB_LO] & I_PC_GROUP_EN,
                            die_ov: 1'b1};
      assign next_pb_pad[gb] = pamux_resolve(pb_ovr[gb], I_PB_DIR[gb], I_PB_OUT[gb],
                                             I_GLOBAL_PULLUP_DISABLE, I_SLEEP);
      // pad level seen by pin change logic through the input buffer
      assign next_pc_src[gb - PAMUX_PB_LO] = I_PB_PAD_IN[gb - PAMUX_PB_LO]
                                             & next_pb_pad[gb].in_en;
    end
  endgenerate

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // pad controls and analog path
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_PA_PAD <= {8{PAMUX_PAD_RST}};
      O_PB_PAD <= {7{PAMUX_PAD_RST}};
      O_PA_ANALOG_EN <= PAMUX_BYTE_RST;
      O_PA_ANALOG_LINE <= PAMUX_BYTE_RST;
    end else begin
      O_PA_PAD <= next_pa_pad;
      O_PB_PAD <= next_pb_pad;
      O_PA_ANALOG_EN <= pa_lcd_own;
      O_PA_ANALOG_LINE <= next_pa_line;
    end
  end

  // inputs handed back to pin change and spi
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_PIN_CHANGE_SRC <= PAMUX_PB_RST;
      O_SPI_MASTER_IN <= PAMUX_BIT_RST;
      O_SPI_SLAVE_IN <= PAMUX_BIT_RST;
      O_SPI_SCK_IN <= PAMUX_BIT_RST;
    end else begin
      O_PIN_CHANGE_SRC <= next_pc_src;
      O_SPI_MASTER_IN <= I_PB_PAD_IN[PAMUX_PB_MISO - PAMUX_PB_LO];
      O_SPI_SLAVE_IN <= I_PB_PAD_IN[PAMUX_PB_MOSI - PAMUX_PB_LO];
      O_SPI_SCK_IN <= I_PB_PAD_IN[PAMUX_PB_SCK - PAMUX_PB_LO];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // checks stay off until one edge after reset release, so no attempt sees reset values
  logic chk_live; // reset released for a full cycle
  always_ff @(posedge I_REF_CLK) begin
    chk_live <= I_RST_N;
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N || !chk_live);

  // lcd on: one cycle later a segment pin neither drives, pulls nor listens
  sequence s_lcd_on;
    I_LCD_ENABLE;
  endsequence
  a_lcd_seg_force: assert property (s_lcd_on |=> !O_PA_PAD[7].drv_en && !O_PA_PAD[7].pull_en
                                    && !O_PA_PAD[7].in_en && O_PA_ANALOG_EN[7])
    else $error("segment pin not released to lcd");

  // com1 without qualifier stays plain gpio
  a_lcd_com_qual: assert property (I_LCD_ENABLE && !I_LCD_MUX_QUALIFIER[0]
                                   |=> O_PA_PAD[1].drv_en == $past(I_PA_DIR[1]))
    else $error("com1 overridden without qualifier");

  // segment and common lines land on the right pins
  a_lcd_line_map: assert property (##1 O_PA_ANALOG_LINE[7] == $past(I_LCD_SEGMENT_LINE[3])
                                   && O_PA_ANALOG_LINE[0] == $past(I_LCD_COMMON_LINE[0]))
    else $error("lcd line routed to wrong pin");

  // timer2 compare on pb7 only through an output-configured pin
  a_tmr_pb7_drive: assert property (I_TMR_CMP_EN[3] && I_PB_DIR[7]
                                    |=> O_PB_PAD[7].drv_en
                                    && O_PB_PAD[7].drv_val == $past(I_TMR_CMP_OUT[3]))
    else $error("timer2 compare not on pb7");

  // timer0 compare does not enable the driver on an input pin
  a_tmr_pb4_input: assert property (I_TMR_CMP_EN[0] && !I_PB_DIR[4] |=> !O_PB_PAD[4].drv_en)
    else $error("pb4 driven while input");

  // pin change source follows pad while the buffer is on
  a_pc_src_map: assert property (I_PC_MASK[6] && I_PC_GROUP_EN
                                 |=> O_PIN_CHANGE_SRC[6] == $past(I_PB_PAD_IN[6]))
    else $error("pin change source 15 wrong");

  // master forces miso to input with pull-up from the port bit
  sequence s_spi_master;
    I_SPI_ENABLE && I_SPI_MASTER;
  endsequence
  a_spi_miso_in: assert property (s_spi_master |=> !O_PB_PAD[3].drv_en
                                  && O_PB_PAD[3].pull_en == $past(I_PB_OUT[3]
                                  && !I_GLOBAL_PULLUP_DISABLE))
    else $error("miso not forced to input");

  // slave forces mosi and sck to input
  a_spi_slave_in: assert property (I_SPI_ENABLE && !I_SPI_MASTER
                                   |=> !O_PB_PAD[2].drv_en && !O_PB_PAD[1].drv_en)
    else $error("slave inputs driven");

  // master drives mosi and sck values from the spi
  a_spi_mst_out: assert property (s_spi_master ##0 I_PB_DIR[1]
                                  |=> O_PB_PAD[1].drv_en
                                  && O_PB_PAD[1].drv_val == $past(I_SPI_SCK_OUT)
                                  && O_PB_PAD[2].drv_val == $past(I_SPI_MASTER_OUT))
    else $error("master outputs not driven");

  // slave drives miso value
  a_spi_slv_out: assert property (I_SPI_ENABLE && !I_SPI_MASTER
                                  |=> O_PB_PAD[3].drv_val == $past(I_SPI_SLAVE_OUT))
    else $error("slave output not on miso");

  // plain gpio pull-up decode with lcd off
  a_gpio_pull: assert property (!I_LCD_ENABLE
                                |=> O_PA_PAD[5].pull_en == $past(!I_PA_DIR[5] && I_PA_OUT[5]
                                    && !I_GLOBAL_PULLUP_DISABLE))
    else $error("gpio pull-up decode wrong");

  // plain gpio direction, value and input enable with lcd off
  a_gpio_plain: assert property (!I_LCD_ENABLE |=> O_PA_PAD[6].drv_en == $past(I_PA_DIR[6])
                                 && O_PA_PAD[6].drv_val == $past(I_PA_OUT[6])
                                 && O_PA_PAD[6].in_en == $past(!I_SLEEP))
    else $error("gpio path wrong");

  // common line 0 follows lcd_enable alone
  a_lcd_com0_own: assert property (s_lcd_on |=> !O_PA_PAD[0].drv_en && !O_PA_PAD[0].pull_en
                                   && !O_PA_PAD[0].in_en && O_PA_ANALOG_EN[0])
    else $error("common line 0 not released to lcd");

  // qualified common line 3 released to lcd
  a_lcd_com_gate: assert property (I_LCD_ENABLE && I_LCD_MUX_QUALIFIER[2]
                                   |=> O_PA_ANALOG_EN[3] && !O_PA_PAD[3].drv_en)
    else $error("common line 3 not released with qualifier");

  // lcd ownership leaves value and toggle idle on the segment pins
  a_lcd_seg_value: assert property (s_lcd_on
                                    |=> O_PA_PAD[4].drv_val == $past(I_PA_OUT[4]))
    else $error("segment pin value overridden");

  // timer1 compare b on pb6 through an output pin
  a_tmr_pb6_drive: assert property (I_TMR_CMP_EN[2] && I_PB_DIR[6]
                                    |=> O_PB_PAD[6].drv_en
                                    && O_PB_PAD[6].drv_val == $past(I_TMR_CMP_OUT[2]))
    else $error("timer1 compare b not on pb6");

  // timer1 compare a on pb5 through an output pin
  a_tmr_pb5_drive: assert property (I_TMR_CMP_EN[1] && I_PB_DIR[5]
                                    |=> O_PB_PAD[5].drv_en
                                    && O_PB_PAD[5].drv_val == $past(I_TMR_CMP_OUT[1]))
    else $error("timer1 compare a not on pb5");

  // timer0 compare a on pb4 through an output pin
  a_tmr_pb4_drive: assert property (I_TMR_CMP_EN[0] && I_PB_DIR[4]
                                    |=> O_PB_PAD[4].drv_en
                                    && O_PB_PAD[4].drv_val == $past(I_TMR_CMP_OUT[0]))
    else $error("timer0 compare a not on pb4");

  // sleeping pin without its pin change enable shows no source level
  a_pc_src_sleep: assert property (I_SLEEP && !(I_PC_MASK[0] && I_PC_GROUP_EN)
                                   |=> !O_PIN_CHANGE_SRC[0])
    else $error("pin change source 9 passed while asleep");

  // slave role: miso direction from its own bit
  sequence s_spi_slave;
    I_SPI_ENABLE && !I_SPI_MASTER;
  endsequence
  a_spi_miso_dir: assert property (s_spi_slave
                                   |=> O_PB_PAD[3].drv_en == $past(I_PB_DIR[3]))
    else $error("miso direction not from its bit");

  // slave role: forced sck input keeps its port-bit pull-up
  a_spi_slv_pull: assert property (s_spi_slave |=> O_PB_PAD[1].pull_en == $past(I_PB_OUT[1]
                                   && !I_GLOBAL_PULLUP_DISABLE))
    else $error("forced sck input lost its pull-up");

  // master role: mosi direction from its own bit
  a_spi_mosi_dir: assert property (s_spi_master
                                   |=> O_PB_PAD[2].drv_en == $past(I_PB_DIR[2]))
    else $error("mosi direction not from its bit");

  // received spi levels come from the pads one cycle later
  a_spi_rx_path: assert property (##1 O_SPI_MASTER_IN == $past(I_PB_PAD_IN[2])
                                  && O_SPI_SLAVE_IN == $past(I_PB_PAD_IN[1])
                                  && O_SPI_SCK_IN == $past(I_PB_PAD_IN[0]))
    else $error("spi input not taken from pad");

  // pb7 with no compare and no pin change enable is plain gpio
  a_gpio_pb7: assert property (!I_TMR_CMP_EN[3] && !(I_PC_MASK[6] && I_PC_GROUP_EN)
                               |=> O_PB_PAD[7].drv_en == $past(I_PB_DIR[7])
                               && O_PB_PAD[7].drv_val == $past(I_PB_OUT[7])
                               && O_PB_PAD[7].in_en == $past(!I_SLEEP))
    else $error("pb7 not plain gpio");

endmodule : pamux_port_ab

// ===== sim/pamux_periph_model.sv
// peripheral side model: lcd lines, timer compare outputs, spi outputs, outside pad drivers
// assumes one clock shared with the mux; values move only at rising edges
module pamux_periph_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // spi role
  input wire logic i_spi_enable,
  input wire logic i_spi_master,
  // peripheral values
  output logic [3:0] o_seg_line,
  output logic [3:0] o_com_line,
  output logic [3:0] o_cmp_out,
  output logic o_slave_out,
  output logic o_master_out,
  output logic o_sck_out,
  // outside level on port b pads when the mux does not drive them
  output logic [6:0] o_ext_pad
);
  // ----------------------------------------
  // free-running pattern source
  // ----------------------------------------
  logic [7:0] cnt = 8'h00; // pattern counter
  always @(posedge i_clk) begin
    if (!i_rst_n) cnt <= 8'h00;
    else cnt <= cnt + 8'h01;
  end
  assign o_seg_line = cnt[3:0];
  assign o_com_line = ~cnt[4:1];
  assign o_cmp_out = cnt[5:2] ^ cnt[3:0];
  assign o_slave_out = cnt[1];
  assign o_master_out = cnt[2];
  // serial clock stands still unless the master runs it
  assign o_sck_out = i_spi_enable & i_spi_master & cnt[0];
  // undriven pads see a pattern that changes every cycle out of reset
  assign o_ext_pad = cnt[6:0] ^ 7'h2A;
endmodule : pamux_periph_model

// ===== sim/pamux_port_ab_tb.sv
// self-checking bench for the port a / port b alternate function mux
// assumes outputs registered one cycle after the inputs they answer
module pamux_port_ab_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pamux_pkg::*;
  // ----------------------------------------
  // stimulus and observation signals
  // ----------------------------------------
  logic I_REF_CLK = 1'b0, I_RST_N = 1'b0;
  logic [7:0] I_PA_DIR = 8'h00, I_PA_OUT = 8'h00, I_PB_DIR = 8'h00, I_PB_OUT = 8'h00;
  logic I_GLOBAL_PULLUP_DISABLE = 1'b0, I_SLEEP = 1'b0, I_LCD_ENABLE = 1'b0;
  logic [2:0] I_LCD_MUX_QUALIFIER = 3'h0;
  logic [3:0] I_TMR_CMP_EN = 4'h0;
  logic I_SPI_ENABLE = 1'b0, I_SPI_MASTER = 1'b0, I_PC_GROUP_EN = 1'b0;
  logic [6:0] I_PC_MASK = 7'h00, I_PB_PAD_IN, ext_pad;
  logic [3:0] seg_line, com_line, cmp_out;
  logic slave_out, master_out, sck_out;
  pamux_pad_t [7:0] O_PA_PAD;
  pamux_pad_t [7:1] O_PB_PAD;
  logic [7:0] O_PA_ANALOG_EN, O_PA_ANALOG_LINE;
  logic [6:0] O_PIN_CHANGE_SRC;
  logic O_SPI_MASTER_IN, O_SPI_SLAVE_IN, O_SPI_SCK_IN;
  int error_cnt = 0, compares = 0;
  always #5 I_REF_CLK = ~I_REF_CLK;
  // pad level: mux driver wins, otherwise the outside driver
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      I_PB_PAD_IN[k] = (O_PB_PAD[k+1].drv_en === 1'b1) ? O_PB_PAD[k+1].drv_val : ext_pad[k];
    end
  end
  // ----------------------------------------
  // instances
  // ----------------------------------------
  pamux_periph_model periph (.i_clk(I_REF_CLK), .i_rst_n(I_RST_N),
    .i_spi_enable(I_SPI_ENABLE), .i_spi_master(I_SPI_MASTER), .o_seg_line(seg_line),
    .o_com_line(com_line), .o_cmp_out(cmp_out), .o_slave_out(slave_out),
    .o_master_out(master_out), .o_sck_out(sck_out), .o_ext_pad(ext_pad));
  pamux_port_ab dut (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_PA_DIR(I_PA_DIR),
    .I_PA_OUT(I_PA_OUT), .I_PB_DIR(I_PB_DIR), .I_PB_OUT(I_PB_OUT),
    .I_GLOBAL_PULLUP_DISABLE(I_GLOBAL_PULLUP_DISABLE), .I_SLEEP(I_SLEEP),
    .I_LCD_ENABLE(I_LCD_ENABLE), .I_LCD_MUX_QUALIFIER(I_LCD_MUX_QUALIFIER),
    .I_LCD_SEGMENT_LINE(seg_line), .I_LCD_COMMON_LINE(com_line),
    .I_TMR_CMP_EN(I_TMR_CMP_EN), .I_TMR_CMP_OUT(cmp_out), .I_SPI_ENABLE(I_SPI_ENABLE),
    .I_SPI_MASTER(I_SPI_MASTER), .I_SPI_SLAVE_OUT(slave_out),
    .I_SPI_MASTER_OUT(master_out), .I_SPI_SCK_OUT(sck_out), .I_PC_MASK(I_PC_MASK),
    .I_PC_GROUP_EN(I_PC_GROUP_EN), .I_PB_PAD_IN(I_PB_PAD_IN), .O_PA_PAD(O_PA_PAD),
    .O_PB_PAD(O_PB_PAD), .O_PA_ANALOG_EN(O_PA_ANALOG_EN),
    .O_PA_ANALOG_LINE(O_PA_ANALOG_LINE), .O_PIN_CHANGE_SRC(O_PIN_CHANGE_SRC),
    .O_SPI_MASTER_IN(O_SPI_MASTER_IN), .O_SPI_SLAVE_IN(O_SPI_SLAVE_IN),
    .O_SPI_SCK_IN(O_SPI_SCK_IN));
  // ----------------------------------------
  // checking tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // predict at the falling edge, compare just after the next rising edge
  task automatic step(input int n);
    pamux_pad_t [7:0] e_pa;
    pamux_pad_t [7:1] e_pb;
    logic [7:0] e_aen;
    logic [6:0] e_pc;
    logic [2:0] e_spi;
    logic [3:0] q4;
    logic [7:0] e_line;
    logic own, frc, pvo, pvv;
    repeat (n) begin
      @(negedge I_REF_CLK);
      q4 = {I_LCD_MUX_QUALIFIER, 1'b1};
      for (int i = 0; i < 8; i++) begin
        own = I_LCD_ENABLE & ((i >= 4) ? 1'b1 : q4[i%4]);
        e_aen[i] = own;
        // lcd ownership forces driver, pull-up and input off
        e_pa[i] = own ? {1'b0, I_PA_OUT[i], 2'b00} : {I_PA_DIR[i], I_PA_OUT[i],
          ~I_PA_DIR[i] & I_PA_OUT[i] & ~I_GLOBAL_PULLUP_DISABLE, ~I_SLEEP};
      end
      for (int i = 1; i < 8; i++) begin
        frc = 1'b0;
        pvo = 1'b0;
        pvv = 1'b0;
        if (i >= 4) begin
          pvo = I_TMR_CMP_EN[i-4];
          pvv = cmp_out[i-4];
        end else if (i == 3) begin
          frc = I_SPI_ENABLE & I_SPI_MASTER;
          pvo = I_SPI_ENABLE & ~I_SPI_MASTER;
          pvv = slave_out;
        end else begin
          frc = I_SPI_ENABLE & ~I_SPI_MASTER;
          pvo = I_SPI_ENABLE & I_SPI_MASTER;
          pvv = (i == 2) ? master_out : sck_out;
        end
        e_pb[i].drv_en = frc ? 1'b0 : I_PB_DIR[i];
        e_pb[i].drv_val = pvo ? pvv : I_PB_OUT[i];
        e_pb[i].pull_en = I_PB_OUT[i] & ~I_GLOBAL_PULLUP_DISABLE & (frc | ~I_PB_DIR[i]);
        e_pb[i].in_en = (I_PC_MASK[i-1] & I_PC_GROUP_EN) | ~I_SLEEP;
        e_pc[i-1] = I_PB_PAD_IN[i-1] & e_pb[i].in_en;
      end
      e_spi = I_PB_PAD_IN[2:0];
      // lines taken before the edge that moves the pattern source
      e_line = {seg_line, com_line};
      if (!I_RST_N) begin
        e_pa = '0;
        e_pb = '0;
        e_aen = 8'h00;
        e_pc = 7'h00;
        e_spi = 3'h0;
        e_line = 8'h00;
      end
      @(posedge I_REF_CLK);
      #1;
      chk(32'(O_PA_PAD), 32'(e_pa));
      chk(32'(O_PA_ANALOG_EN), 32'(e_aen));
      chk(32'(O_PA_ANALOG_LINE), 32'(e_line));
      chk(32'(O_PB_PAD), 32'(e_pb));
      chk(32'(O_PIN_CHANGE_SRC), 32'(e_pc));
      chk(32'({O_SPI_MASTER_IN, O_SPI_SLAVE_IN, O_SPI_SCK_IN}), 32'(e_spi));
    end
  endtask : step
  // counts, verdict and end of run
  task automatic wrap_up;
    $display("compares %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [4:0] v;
    step(20);
    @(posedge I_REF_CLK) I_RST_N <= 1'b1;
    // mixed settings sweep every qualifier value with sleep on and off; spi role and pull-up disable follow from those bits
    for (int i = 0; i < 32; i++) begin
      v = i[4:0];
      @(posedge I_REF_CLK);
      I_LCD_ENABLE <= v[0];
      I_LCD_MUX_QUALIFIER <= v[3:1];
      I_SPI_ENABLE <= v[1] | v[3];
      I_SPI_MASTER <= v[2];
      I_GLOBAL_PULLUP_DISABLE <= v[3] & v[4];
      I_SLEEP <= v[4];
      I_TMR_CMP_EN <= v[3:0] ^ 4'h5;
      I_PA_DIR <= 8'hC3 ^ {v, v[2:0]};
      I_PA_OUT <= 8'h5A ^ {v[2:0], v};
      I_PB_DIR <= 8'h3C ^ {v, v[2:0]};
      I_PB_OUT <= 8'hA5 ^ {v[1:0], v, v[0]};
      I_PC_MASK <= 7'h55 ^ {v, v[1:0]};
      I_PC_GROUP_EN <= v[0] ^ v[4];
      step(3);
    end
    // all spi pins set as outputs: each role must force its inputs
    for (int m = 0; m < 2; m++) begin
      @(posedge I_REF_CLK);
      I_PB_DIR <= 8'hFE;
      I_PB_OUT <= 8'hFE;
      I_SPI_ENABLE <= 1'b1;
      I_SPI_MASTER <= m[0];
      I_GLOBAL_PULLUP_DISABLE <= 1'b0;
      step(3);
    end
    // reset again in mid-run, then recover
    @(posedge I_REF_CLK) I_RST_N <= 1'b0;
    step(2);
    @(posedge I_REF_CLK) I_RST_N <= 1'b1;
    step(3);
    wrap_up();
  end
endmodule : pamux_port_ab_tb
